/* File: core/buck_regs_consts.vh */
// Constants for the buck regulator control register bank.
// Assumes inclusion by bare name from the core modules.
`ifndef BUCK_REGS_CONSTS_VH
`define BUCK_REGS_CONSTS_VH

// Register addresses on the internal 8-bit register port.
`define ADDR_BUCK1B_MODE_SELECT 8'h00
`define ADDR_BUCK1B_CONFIG 8'h01
`define ADDR_BUCK2_NORMAL_VOLTAGE 8'h02
`define ADDR_BUCK2_STANDBY_VOLTAGE 8'h03
`define ADDR_BUCK2_SLEEP_VOLTAGE 8'h04
`define ADDR_BUCK2_MODE_SELECT 8'h05
`define ADDR_BUCK2_CONFIG 8'h06
`define ADDR_BUCK3_NORMAL_VOLTAGE 8'h07

// Implemented-bit masks.
`define MASK_MODE 8'h2f
`define MASK_CONF 8'h7d
`define MASK_VOLT_RANGE 8'h3f
`define MASK_VOLT_PLAIN 8'h1f

// Field positions.
`define BIT_TURNOFF 5
`define BIT_RAMP 6
`define BIT_RANGE 5

// Power state codes.
`define PSTATE_NORMAL 2'h0
`define PSTATE_STANDBY 2'h1
`define PSTATE_SLEEP 2'h2

// Ramp step intervals in ns and the clock period in ns.
`define RAMP_FAST_NS 2000
`define RAMP_SLOW_NS 4000
`define CLK_PERIOD_NS 8

`endif

/* File: core/buck_reg8.v */
// One 8-bit register with an implemented-bit mask and an OTP default.
// Assumes otp_value is stable when otp_load pulses after reset.
`timescale 1ns/1ps
`default_nettype none
module buck_reg8 #(
    parameter [7:0] MASK = 8'hff
)
(
    input wire clk,
    input wire rstn,
    input wire otp_load,
    input wire [7:0] otp_value,
    input wire wr_en,
    input wire [7:0] wr_data,
    output wire [7:0] value
);
    reg [7:0] store;

    // Load the OTP default after reset, then take writes at any time.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            store <= 8'h00;
        else if (otp_load)
            store <= otp_value & MASK;
        else if (wr_en)
            store <= wr_data & MASK;
    end

    // Unimplemented bits always read as zero.
    assign value = store & MASK;
endmodule
`default_nettype wire

/* File: core/buck_ramp.v */
// Voltage step pacer: moves a 6-bit code one step per ramp interval.
// Assumes target is a register value; interval counts are in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module buck_ramp #(
    parameter integer FAST_CYCLES = 250,
    parameter integer SLOW_CYCLES = 500
)
(
    input wire clk,
    input wire rstn,
    input wire load,
    input wire slow,
    input wire [5:0] target,
    output reg [5:0] level,
    output wire settled
);
    reg [15:0] count;
    wire [15:0] limit;

    // Choose the step interval from the ramp rate bit.
    assign limit = slow ? SLOW_CYCLES[15:0] : FAST_CYCLES[15:0];
    assign settled = (level == target);

    // Jump to the target on load, else step toward it once per interval.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            level <= 6'h00;
            count <= 16'h0000;
        end
        else if (load)
        begin
            level <= target;
            count <= 16'h0000;
        end
        else if (settled)
            count <= 16'h0000;
        else if (count >= limit - 16'h0001)
        begin
            count <= 16'h0000;
            level <= (level < target) ? level + 6'h01 : level - 6'h01;
        end
        else
            count <= count + 16'h0001;
    end
endmodule
`default_nettype wire

/* File: core/buck_regulator_control_regs.v */
// Register bank for buck 1 second phase, buck two and buck three.
// Operation
// - Buck1b mode bit 5 picks off or sleep.
// - Buck2 mode bit 5 picks off or sleep.
// - Mode bits 3:0 select switching mode.
// - Config bit 6 sets ramp step interval.
// - Config bits 5:4 select clock phase.
// - Config bits 3:2 select switching frequency.
// - Config bit 0 selects current limit.
// - Buck2 voltage: code 4:0, range bit 5.
// - Separate buck2 normal voltage register.
// - Separate buck2 standby voltage register.
// - Separate buck2 sleep voltage register.
// - Buck3 normal voltage: 5-bit code only.
// - All registers readable and writable anytime.
// - Reset defaults come from OTP memory.
// Assumes a serial bus front end gives an 8-bit address, write strobe and data.
`timescale 1ns/1ps
`default_nettype none
`include "buck_regs_consts.vh"
module buck_regulator_control_regs #(
    parameter integer FAST_CYCLES = `RAMP_FAST_NS / `CLK_PERIOD_NS,
    parameter integer SLOW_CYCLES = `RAMP_SLOW_NS / `CLK_PERIOD_NS
)
(
    input wire clk,
    input wire rstn,
    input wire [63:0] otp_defaults,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_ack,
    input wire [1:0] power_state,
    input wire buck1b_turnoff_event,
    input wire buck2_turnoff_event,
    output wire buck1b_turnoff_state,
    output wire [3:0] buck1b_switch_mode,
    output wire buck1b_ramp_rate,
    output wire [1:0] buck1b_clock_phase,
    output wire [1:0] buck1b_switch_freq,
    output wire buck1b_current_limit,
    output wire buck2_turnoff_state,
    output wire [3:0] buck2_switch_mode,
    output wire buck2_ramp_rate,
    output wire [1:0] buck2_clock_phase,
    output wire [1:0] buck2_switch_freq,
    output wire buck2_current_limit,
    output reg [4:0] buck2_code,
    output reg buck2_high_range,
    output wire [5:0] buck2_level,
    output wire buck2_settled,
    output reg [4:0] buck_three_code,
    output reg buck1b_sleeping,
    output reg buck2_sleeping,
    output reg buck1b_off,
    output reg buck2_off
);
    // Start-up sequencer states.
    localparam ST_LOAD = 2'd0;
    localparam ST_RUN = 2'd1;

    reg [1:0] state;
    reg otp_load;
    reg target_load;
    reg start_jump;
    reg [5:0] next_target;
    // Masked register contents, one per address.
    wire [7:0] r_mode1b;
    wire [7:0] r_conf1b;
    wire [7:0] r_norm2;
    wire [7:0] r_stby2;
    wire [7:0] r_sleep2;
    wire [7:0] r_mode2;
    wire [7:0] r_conf2;
    wire [7:0] r_norm3;
    // Write strobes, one per address.
    wire wr_mode1b;
    wire wr_conf1b;
    wire wr_norm2;
    wire wr_stby2;
    wire wr_sleep2;
    wire wr_mode2;
    wire wr_conf2;
    wire wr_norm3;

    // Decode a register write strobe for one address.
    function wr_hit;
        input [7:0] addr;
        input [7:0] want;
        input wr;
        begin
            wr_hit = wr && (addr == want);
        end
    endfunction

    // Power state codes outside standby and sleep count as normal operation.
    function in_normal;
        input [1:0] pstate;
        begin
            in_normal = (pstate != `PSTATE_STANDBY) && (pstate != `PSTATE_SLEEP);
        end
    endfunction

    // Pulse the OTP load once after reset release, then run.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_LOAD;
            otp_load <= 1'b0;
        end
        else
        begin
            case (state)
                ST_LOAD:
                begin
                    otp_load <= 1'b1;
                    state <= ST_RUN;
                end
                ST_RUN:
                    otp_load <= 1'b0;
                default:
                begin
                    otp_load <= 1'b0;
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Write strobes for the eight addresses; writes are taken at any time.
    assign wr_mode1b = wr_hit(reg_addr, `ADDR_BUCK1B_MODE_SELECT, reg_wr);
    assign wr_conf1b = wr_hit(reg_addr, `ADDR_BUCK1B_CONFIG, reg_wr);
    assign wr_norm2 = wr_hit(reg_addr, `ADDR_BUCK2_NORMAL_VOLTAGE, reg_wr);
    assign wr_stby2 = wr_hit(reg_addr, `ADDR_BUCK2_STANDBY_VOLTAGE, reg_wr);
    assign wr_sleep2 = wr_hit(reg_addr, `ADDR_BUCK2_SLEEP_VOLTAGE, reg_wr);
    assign wr_mode2 = wr_hit(reg_addr, `ADDR_BUCK2_MODE_SELECT, reg_wr);
    assign wr_conf2 = wr_hit(reg_addr, `ADDR_BUCK2_CONFIG, reg_wr);
    assign wr_norm3 = wr_hit(reg_addr, `ADDR_BUCK3_NORMAL_VOLTAGE, reg_wr);

    // The eight registers, each masked to its implemented bits.
    buck_reg8 #(.MASK(`MASK_MODE)) u_mode1b (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[7:0]),
        .wr_en(wr_mode1b),
        .wr_data(reg_wdata),
        .value(r_mode1b)
    );
    buck_reg8 #(.MASK(`MASK_CONF)) u_conf1b (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[15:8]),
        .wr_en(wr_conf1b),
        .wr_data(reg_wdata),
        .value(r_conf1b)
    );
    buck_reg8 #(.MASK(`MASK_VOLT_RANGE)) u_norm2 (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[23:16]),
        .wr_en(wr_norm2),
        .wr_data(reg_wdata),
        .value(r_norm2)
    );
    buck_reg8 #(.MASK(`MASK_VOLT_RANGE)) u_stby2 (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[31:24]),
        .wr_en(wr_stby2),
        .wr_data(reg_wdata),
        .value(r_stby2)
    );
    buck_reg8 #(.MASK(`MASK_VOLT_RANGE)) u_sleep2 (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[39:32]),
        .wr_en(wr_sleep2),
        .wr_data(reg_wdata),
        .value(r_sleep2)
    );
    buck_reg8 #(.MASK(`MASK_MODE)) u_mode2 (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[47:40]),
        .wr_en(wr_mode2),
        .wr_data(reg_wdata),
        .value(r_mode2)
    );
    buck_reg8 #(.MASK(`MASK_CONF)) u_conf2 (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[55:48]),
        .wr_en(wr_conf2),
        .wr_data(reg_wdata),
        .value(r_conf2)
    );
    buck_reg8 #(.MASK(`MASK_VOLT_PLAIN)) u_norm3 (
        .clk(clk),
        .rstn(rstn),
        .otp_load(otp_load),
        .otp_value(otp_defaults[63:56]),
        .wr_en(wr_norm3),
        .wr_data(reg_wdata),
        .value(r_norm3)
    );

    // Mode fields to the regulators.
    assign buck1b_turnoff_state = r_mode1b[`BIT_TURNOFF];
    assign buck2_turnoff_state = r_mode2[`BIT_TURNOFF];
    assign buck1b_switch_mode = r_mode1b[3:0];
    assign buck2_switch_mode = r_mode2[3:0];

    // Configuration fields to the regulators.
    assign buck1b_ramp_rate = r_conf1b[`BIT_RAMP];
    assign buck2_ramp_rate = r_conf2[`BIT_RAMP];
    assign buck1b_clock_phase = r_conf1b[5:4];
    assign buck2_clock_phase = r_conf2[5:4];
    assign buck1b_switch_freq = r_conf1b[3:2];
    assign buck2_switch_freq = r_conf2[3:2];
    assign buck1b_current_limit = r_conf1b[0];
    assign buck2_current_limit = r_conf2[0];

    // Read mux; unmapped addresses and reserved bits read as zero.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
        end
        else
        begin
            reg_ack <= reg_rd | reg_wr;
            if (reg_rd)
            begin
                case (reg_addr)
                    `ADDR_BUCK1B_MODE_SELECT: reg_rdata <= r_mode1b;
                    `ADDR_BUCK1B_CONFIG: reg_rdata <= r_conf1b;
                    `ADDR_BUCK2_NORMAL_VOLTAGE: reg_rdata <= r_norm2;
                    `ADDR_BUCK2_STANDBY_VOLTAGE: reg_rdata <= r_stby2;
                    `ADDR_BUCK2_SLEEP_VOLTAGE: reg_rdata <= r_sleep2;
                    `ADDR_BUCK2_MODE_SELECT: reg_rdata <= r_mode2;
                    `ADDR_BUCK2_CONFIG: reg_rdata <= r_conf2;
                    `ADDR_BUCK3_NORMAL_VOLTAGE: reg_rdata <= r_norm3;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Pick the buck two voltage register for the present power state.
    always @*
    begin
        case (power_state)
            `PSTATE_STANDBY: next_target = r_stby2[5:0];
            `PSTATE_SLEEP: next_target = r_sleep2[5:0];
            default: next_target = r_norm2[5:0];
        endcase
    end

    // Register the active targets; refresh them on every clock cycle.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buck2_code <= 5'h00;
            buck2_high_range <= 1'b0;
            buck_three_code <= 5'h00;
            target_load <= 1'b0;
            start_jump <= 1'b0;
        end
        else
        begin
            buck2_code <= next_target[4:0];
            buck2_high_range <= next_target[`BIT_RANGE];
            buck_three_code <= r_norm3[4:0];
            // The start-up jump waits until the OTP code has reached buck2_code.
            target_load <= otp_load;
            start_jump <= target_load;
        end
    end

    // Paced voltage stepping for buck two using its ramp rate bit.
    // The level jumps once to the OTP target after reset, then ramps.
    buck_ramp #(.FAST_CYCLES(FAST_CYCLES), .SLOW_CYCLES(SLOW_CYCLES)) u_ramp2 (
        .clk(clk),
        .rstn(rstn),
        .load(start_jump),
        .slow(buck2_ramp_rate),
        .target({buck2_high_range, buck2_code}),
        .level(buck2_level),
        .settled(buck2_settled)
    );

    // Turn-off events drive each regulator to off or sleep per its mode bit.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buck1b_sleeping <= 1'b0;
            buck1b_off <= 1'b0;
            buck2_sleeping <= 1'b0;
            buck2_off <= 1'b0;
        end
        else
        begin
            if (buck1b_turnoff_event)
            begin
                buck1b_sleeping <= buck1b_turnoff_state;
                buck1b_off <= ~buck1b_turnoff_state;
            end
            else if (in_normal(power_state))
            begin
                buck1b_sleeping <= 1'b0;
                buck1b_off <= 1'b0;
            end
            // Buck two follows the same rule with its own mode bit.
            if (buck2_turnoff_event)
            begin
                buck2_sleeping <= buck2_turnoff_state;
                buck2_off <= ~buck2_turnoff_state;
            end
            else if (in_normal(power_state))
            begin
                buck2_sleeping <= 1'b0;
                buck2_off <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/buck_regs_monitor.sv */
// Checker for the buck register bank: read-back agrees with the field outputs.
// Assumes it is bound to the bank's top module and reads never share an edge with writes.
`timescale 1ns/1ps
`default_nettype none
module buck_regs_monitor
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic [1:0] power_state,
    input wire logic buck1b_turnoff_event,
    input wire logic buck2_turnoff_event,
    input wire logic buck1b_turnoff_state,
    input wire logic [3:0] buck1b_switch_mode,
    input wire logic buck1b_ramp_rate,
    input wire logic [1:0] buck1b_clock_phase,
    input wire logic [1:0] buck1b_switch_freq,
    input wire logic buck1b_current_limit,
    input wire logic buck2_turnoff_state,
    input wire logic [3:0] buck2_switch_mode,
    input wire logic buck2_ramp_rate,
    input wire logic [1:0] buck2_clock_phase,
    input wire logic [1:0] buck2_switch_freq,
    input wire logic buck2_current_limit,
    input wire logic [4:0] buck2_code,
    input wire logic buck2_high_range,
    input wire logic [4:0] buck_three_code,
    input wire logic buck1b_sleeping,
    input wire logic buck2_sleeping,
    input wire logic buck1b_off,
    input wire logic buck2_off
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // A read of a mode or config register returns what the field outputs show.
    property p_mode(a, t, m);
        reg_rd && !reg_wr && reg_addr == a |=> reg_rdata[5] == t && reg_rdata[3:0] == m;
    endproperty
    property p_conf(a, r, p, f, l);
        reg_rd && !reg_wr && reg_addr == a |=>
            reg_rdata[6] == r && reg_rdata[5:4] == p && reg_rdata[3:2] == f && reg_rdata[0] == l;
    endproperty
    sequence s_sel;
        reg_rd && !reg_wr && (reg_addr == 8'h02 && power_state != 2'h1 && power_state != 2'h2
            || reg_addr == 8'h03 && power_state == 2'h1
            || reg_addr == 8'h04 && power_state == 2'h2);
    endsequence

    AST_ACK: assert property (reg_ack == $past(reg_wr || reg_rd))
        else $error("ack does not follow the access");
    AST_B1_MODE: assert property (
        p_mode(8'h00, buck1b_turnoff_state, buck1b_switch_mode))
        else $error("buck1b mode fields differ from register");
    AST_B2_MODE: assert property (
        p_mode(8'h05, buck2_turnoff_state, buck2_switch_mode))
        else $error("buck2 mode fields differ from register");
    AST_B1_CONF: assert property (
        p_conf(8'h01, buck1b_ramp_rate, buck1b_clock_phase,
            buck1b_switch_freq, buck1b_current_limit))
        else $error("buck1b config fields differ from register");
    AST_B2_CONF: assert property (
        p_conf(8'h06, buck2_ramp_rate, buck2_clock_phase,
            buck2_switch_freq, buck2_current_limit))
        else $error("buck2 config fields differ from register");
    AST_RSV_CONF: assert property (
        reg_rd && (reg_addr == 8'h01 || reg_addr == 8'h06) |=> (reg_rdata & 8'h82) == 8'h00)
        else $error("reserved config bit reads one");
    AST_B3_CODE: assert property (
        reg_rd && !reg_wr && reg_addr == 8'h07 |=> reg_rdata == {3'h0, buck_three_code})
        else $error("buck three code differs from register");
    AST_B2_SEL: assert property (
        s_sel |=> {buck2_high_range, buck2_code} == reg_rdata[5:0])
        else $error("buck2 target not taken from the active register");
    AST_B1_OFF: assert property (
        power_state == 2'h2 && buck1b_turnoff_event |-> ##[1:2]
            (buck1b_sleeping == buck1b_turnoff_state && buck1b_off != buck1b_turnoff_state))
        else $error("buck1b turn-off state wrong");
    AST_B2_OFF: assert property (
        power_state == 2'h2 && buck2_turnoff_event |-> ##[1:2]
            (buck2_sleeping == buck2_turnoff_state && buck2_off != buck2_turnoff_state))
        else $error("buck2 turn-off state wrong");

    // Main scenarios reached.
    COV_SEL: cover property (s_sel);
    COV_SLEEP: cover property (buck1b_sleeping && buck2_off);
    COV_OFF: cover property (buck1b_off && buck2_sleeping);
endmodule
bind buck_regulator_control_regs buck_regs_monitor u_buck_regs_monitor (.*);
`default_nettype wire

/* File: tb/buck_regulator_control_regs_bench.sv */
// Self-checking bench for the buck register bank.
// Assumes the constants header is on the include path; ramp counts shortened to 2 and 4.
`timescale 1ns/1ps
`default_nettype none
`include "buck_regs_consts.vh"
module buck_regulator_control_regs_bench;
    logic clk, rstn, reg_wr, reg_rd, reg_ack, buck1b_turnoff_event, buck2_turnoff_event;
    logic [63:0] otp_defaults;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] power_state, buck1b_clock_phase, buck1b_switch_freq;
    logic [1:0] buck2_clock_phase, buck2_switch_freq;
    logic [3:0] buck1b_switch_mode, buck2_switch_mode;
    logic [4:0] buck2_code, buck_three_code;
    logic [5:0] buck2_level;
    logic buck1b_turnoff_state, buck1b_ramp_rate, buck1b_current_limit, buck2_turnoff_state;
    logic buck2_ramp_rate, buck2_current_limit, buck2_high_range, buck2_settled;
    logic buck1b_sleeping, buck2_sleeping, buck1b_off, buck2_off;
    integer mismatches = 0;
    integer check_count = 0;
    logic [7:0] off_flags;

    buck_regulator_control_regs #(.FAST_CYCLES(2), .SLOW_CYCLES(4))
        u_buck_regulator_control_regs (.*);

    // Turn-off flags packed as sleep and off for buck1b, then buck two.
    assign off_flags = {4'h0, buck1b_sleeping, buck1b_off, buck2_sleeping, buck2_off};

    // Free-running 125 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Implemented bits of each address; unmapped places read as zero.
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h00, 8'h05: msk = `MASK_MODE;
            8'h01, 8'h06: msk = `MASK_CONF;
            8'h02, 8'h03, 8'h04: msk = `MASK_VOLT_RANGE;
            8'h07: msk = `MASK_VOLT_PLAIN;
            default: msk = 8'h00;
        endcase
    endfunction

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        check({7'h0, reg_ack}, 8'h01);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        check(reg_rdata, exp);
    endtask

    task t_reset(input logic [63:0] otp);
        integer i;
        @(negedge clk);
        otp_defaults = otp;
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        for (i = 0; i < 8; i = i + 1)
            rd(i[7:0], otp[i*8 +: 8] & msk(i[7:0]));
        rd(8'h3f, 8'h00);
        check({2'h0, buck2_level}, otp[23:16] & `MASK_VOLT_RANGE);
        $display("test reset done");
    endtask

    // Distinct patterns per register show the registers are independent.
    task t_rw;
        integer i;
        integer j;
        for (j = 0; j < 2; j = j + 1)
        begin
            for (i = 0; i < 8; i = i + 1)
                wr(i[7:0], {2{i[3:0]}} ^ {8{j[0]}});
            wr(8'h3f, 8'hff);
            for (i = 0; i < 8; i = i + 1)
                rd(i[7:0], ({2{i[3:0]}} ^ {8{j[0]}}) & msk(i[7:0]));
        end
        $display("test read write done");
    endtask

    task t_volt;
        integer s;
        logic [7:0] exp;
        wr(8'h02, 8'h25);
        wr(8'h03, 8'h1a);
        wr(8'h04, 8'h33);
        wr(8'h07, 8'hff);
        for (s = 0; s < 4; s = s + 1)
        begin
            power_state = s[1:0];
            repeat (2) @(negedge clk);
            exp = (s == 1) ? 8'h1a : (s == 2) ? 8'h33 : 8'h25;
            check({2'h0, buck2_high_range, buck2_code}, exp);
        end
        wr(8'h02, 8'h0c);
        repeat (2) @(negedge clk);
        check({2'h0, buck2_high_range, buck2_code}, 8'h0c);
        check({3'h0, buck_three_code}, 8'h1f);
        $display("test voltage done");
    endtask

    task t_turnoff;
        integer j;
        for (j = 0; j < 2; j = j + 1)
        begin
            wr(8'h00, j ? 8'h00 : 8'h20);
            wr(8'h05, j ? 8'h20 : 8'h00);
            power_state = 2'h2;
            @(negedge clk);
            buck1b_turnoff_event = 1'b1;
            buck2_turnoff_event = 1'b1;
            @(negedge clk);
            buck1b_turnoff_event = 1'b0;
            buck2_turnoff_event = 1'b0;
            @(negedge clk);
            check(off_flags, j ? 8'h06 : 8'h09);
            power_state = 2'h0;
            repeat (2) @(negedge clk);
            check(off_flags, 8'h00);
        end
        $display("test turn-off done");
    endtask

    task ramp_to(input logic [7:0] v, output integer n);
        wr(8'h02, v);
        n = 0;
        do
        begin
            @(negedge clk);
            n = n + 1;
        end
        while (buck2_settled !== 1'b1 && n < 200);
        check({2'h0, buck2_level}, v & 8'h3f);
    endtask

    // Eight steps take about 8 x 2 cycles fast and 8 x 4 cycles slow.
    task t_ramp;
        integer n_fast;
        integer n_slow;
        wr(8'h06, 8'h00);
        ramp_to(8'h00, n_fast);
        ramp_to(8'h08, n_fast);
        wr(8'h06, 8'h40);
        ramp_to(8'h00, n_slow);
        check({7'h0, n_fast >= 14 && n_fast <= 20}, 8'h01);
        check({7'h0, n_slow >= 30 && n_slow <= 38}, 8'h01);
        $display("test ramp done");
    endtask

    initial
    begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        power_state = 2'h0;
        buck1b_turnoff_event = 1'b0;
        buck2_turnoff_event = 1'b0;
        otp_defaults = 64'h0000_0000_0000_0000;
        t_reset(64'h3cf0_a5c3_ff81_7e5a);
        t_rw;
        t_volt;
        t_turnoff;
        t_ramp;
        t_reset(64'hc30f_5a3c_007e_81a5);
        stop_test;
    end

    // Tests take about 250 cycles; 5000 cycles means a hang.
    initial
    begin
        #40000;
        mismatches = mismatches + 1;
        stop_test;
    end
endmodule
`default_nettype wire
